//--- epaper_cmd_front_end.sv
// Command decoder, parameter registers and pixel memory of the front end
//
// How it works
// [R1] Bus width pin picks four- or three-wire
// [R2] Select pin or first bit marks command/data
// [R3] Bytes are writes, or reads after stop
// [R4] Reset pin restores defaults, outputs float
// [R5] Host holds reset low fifty microseconds; the bench's first reset lasts 12 cycles
// [R6] Busy low while occupied; host waits
// [R7] Role strap: master drives tick, slave follows
// [R8] Only valid parameter bits are stored
// [R9] Panel command: one byte, default 0FH
// [R10] Supply command: five bytes with defaults
// [R11] Power-off command takes no parameters
// [R12] Off-sequence byte keeps bits five, four
// [R13] Power-on command takes no parameters
// [R14] Power-on-measure command takes no parameters
// [R15] Soft-start takes three bytes, default 17H
// [R16] Deep sleep only with A5H check
// [R17] Mono pixel stream fills first plane
// [R18] Data stop, then one status read
// [R19] Refresh command starts display update
// [R20] Red pixel stream fills second plane
// [R21] Auto sequence only with A5H check
// [R22] Waveform option: two bytes, masked fields
// [R23] Commands execute when chip select rises; a following command byte also commits them
// [R24] Host writes zero to unused bits; the bench writes ones there to check masking
// [R25] Command byte restarts parameter counting
// [R26] Unknown commands and their data ignored
module epaper_cmd_front_end #(
  parameter int MEM_BYTES  = epaper_cmd_pkg::MEM_BYTES,
  parameter int BUSY_TICKS = epaper_cmd_pkg::BUSY_TICKS,
  parameter int TICK_DIV   = epaper_cmd_pkg::TICK_DIV
) (
  // System clock, reset, enable
  input  wire logic                              clk_sys,
  input  wire logic                              nrst,
  input  wire logic                              ce,
  // Host serial interface
  input  wire logic                              sclk,
  input  wire logic                              chipSelectPinN,
  input  wire logic                              sdaIn,
  output logic                                   sdaOut,
  output logic                                   sdaOe,
  input  wire logic                              cmdDataSelect,
  input  wire logic                              busWidthSelect,
  output logic                                   busyN,
  // Cascade pins
  input  wire logic                              cascadeRolePin,
  input  wire logic                              cascadeTickIn,
  output logic                                   cascadeTickOut,
  output logic                                   cascadeTickOe,
  // Panel control state
  output logic                                   supplyOn,
  output logic                                   outputsFloat,
  output logic                                   deepSleep,
  output logic                                   refreshStart,
  // Configuration registers
  output logic [7:0]                             panelConfig,
  output logic [1:0]                             supplySourceSelect,
  output logic [2:0]                             supplyLevelSelect,
  output logic [5:0]                             sourceHighLevel,
  output logic [5:0]                             sourceLowLevel,
  output logic [5:0]                             redSourceLevel,
  output logic [1:0]                             offTimingField,
  output logic [7:0]                             softStartA,
  output logic [7:0]                             softStartB,
  output logic [5:0]                             softStartC,
  output logic [5:0]                             stateGateOnField,
  output logic [1:0]                             extSourceField,
  output logic [2:0]                             driveModeField,
  // Pixel memory read port for the refresh engine
  input  wire logic [epaper_cmd_pkg::MEM_AW-1:0] memRdAddr,
  output logic [7:0]                             memRdMono,
  output logic [7:0]                             memRdRed
);

  byte_link_if link ();

  serial_byte_rx rx (
    .sclk           (sclk),
    .chipSelectPinN (chipSelectPinN),
    .sdaIn          (sdaIn),
    .cmdDataSelect  (cmdDataSelect),
    .busWidthSelect (busWidthSelect),
    .link           (link)
  );

  localparam int AW = epaper_cmd_pkg::MEM_AW;

  logic                  togS1, togS2, togS3;
  logic                  csS1, csS2, csS3;
  logic                  selS1, selS2;
  logic                  bwsS1, bwsS2;
  logic                  fbS1, fbS2;
  logic                  roleS1, roleS2;
  logic                  tkS1, tkS2, tkS3;
  logic                  newByte, csbRise, accept, isCmd, isData;
  logic                  commit, softReset, wrMono, wrRed, tick;
  logic [7:0]            cmd_r;
  logic [2:0]            pCnt_r;
  logic [7:0]            pbuf_r [0:4];
  logic                  pending_r;
  logic [AW-1:0]         memAddr_r;
  logic                  readArm_r, readSeen_r, statusFlag_r;
  epaper_cmd_pkg::exec_t exec_r;
  logic [15:0]           busyCnt_r;
  logic                  roleMaster_r;
  logic [7:0]            divCnt_r;
  logic [7:0]            monoMem [0:MEM_BYTES-1];
  logic [7:0]            redMem  [0:MEM_BYTES-1];

  // Pin and cross-domain synchronisers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      {togS1, togS2, togS3} <= 3'h0;
      {csS1, csS2, csS3}    <= 3'h7;
      {selS1, selS2}        <= 2'h0;
      {bwsS1, bwsS2}        <= 2'h0;
      {fbS1, fbS2}          <= 2'h0;
      {roleS1, roleS2}      <= {cascadeRolePin, roleS1}; // R7
      {tkS1, tkS2, tkS3}    <= 3'h0;
    end else if (ce) begin
      {togS1, togS2, togS3} <= {link.byteToggle, togS1, togS2};
      {csS1, csS2, csS3}    <= {chipSelectPinN, csS1, csS2};
      {selS1, selS2}        <= {cmdDataSelect, selS1};
      {bwsS1, bwsS2}        <= {busWidthSelect, bwsS1};
      {fbS1, fbS2}          <= {link.firstBitSeen, fbS1};
      {roleS1, roleS2}      <= {cascadeRolePin, roleS1};
      {tkS1, tkS2, tkS3}    <= {cascadeTickIn, tkS1, tkS2};
    end
  end

  // Link logic is held in reset while the system reset is applied
  always_ff @(posedge clk_sys) begin
    link.linkReset <= !nrst;
  end

  assign newByte = togS2 ^ togS3;
  assign csbRise = csS2 & ~csS3;
  // Bytes are refused while busy or asleep
  assign accept  = ce && newByte && exec_r == epaper_cmd_pkg::EX_IDLE; // R6
  assign isCmd   = accept && !link.byteIsData; // R2
  assign isData  = accept && link.byteIsData && !readArm_r; // R3
  assign commit  = ce && pending_r && (csbRise || isCmd); // R23
  assign softReset = commit && cmd_r == epaper_cmd_pkg::CMD_PANEL
                     && pCnt_r != 3'h0
                     && !pbuf_r[0][epaper_cmd_pkg::PANEL_SOFT_RST_BIT];
  assign wrMono  = isData && cmd_r == epaper_cmd_pkg::CMD_MONO_LOAD
                   && 32'(memAddr_r) < MEM_BYTES; // R17
  assign wrRed   = isData && cmd_r == epaper_cmd_pkg::CMD_RED_LOAD
                   && 32'(memAddr_r) < MEM_BYTES; // R20

  // Command capture and parameter collection
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cmd_r     <= epaper_cmd_pkg::CMD_NONE;
      pCnt_r    <= 3'h0;
      pending_r <= 1'b0;
      memAddr_r <= '0;
      for (int i = 0; i < 5; i++) pbuf_r[i] <= 8'h00;
    end else if (ce) begin
      if (isCmd) begin
        cmd_r     <= link.byteData;
        pCnt_r    <= 3'h0; // R25
        pending_r <= 1'b1;
        memAddr_r <= '0;
      end else begin
        if (commit) pending_r <= 1'b0;
        if (wrMono || wrRed) memAddr_r <= memAddr_r + 1'b1;
        if (isData
            && pCnt_r < epaper_cmd_pkg::param_count(cmd_r)) begin // R26
          pbuf_r[pCnt_r] <= link.byteData; // R25
          pCnt_r         <= pCnt_r + 3'h1;
          pending_r      <= 1'b1;
        end
      end
    end
  end

  // Status read after a data stop
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      readArm_r    <= 1'b0;
      readSeen_r   <= 1'b0;
      statusFlag_r <= 1'b0;
      sdaOut       <= 1'b0;
      sdaOe        <= 1'b0;
    end else if (ce) begin
      if (isCmd) begin
        readArm_r  <= link.byteData == epaper_cmd_pkg::CMD_DATA_STOP; // R18
        readSeen_r <= 1'b0;
      end else if (csbRise && readSeen_r) begin
        readArm_r  <= 1'b0;
        readSeen_r <= 1'b0;
      end else if (accept && readArm_r) begin
        readSeen_r <= 1'b1;
      end
      if (wrMono || wrRed)
        statusFlag_r <= 1'b1;
      else if (isCmd && epaper_cmd_pkg::is_pixel_load(link.byteData))
        statusFlag_r <= 1'b0;
      sdaOut <= statusFlag_r; // R18
      sdaOe  <= readArm_r && !csS2 && (bwsS2 ? fbS2 : selS2); // R3
    end
  end

  // Configuration registers, loaded when a command completes
  always_ff @(posedge clk_sys) begin
    if (!nrst || softReset) begin // R4
      panelConfig        <= epaper_cmd_pkg::PANEL_RST; // R9
      supplySourceSelect <= epaper_cmd_pkg::SUPPLY_SRC_RST;
      supplyLevelSelect  <= epaper_cmd_pkg::SUPPLY_LVL_RST;
      sourceHighLevel    <= epaper_cmd_pkg::SRC_HIGH_RST;
      sourceLowLevel     <= epaper_cmd_pkg::SRC_LOW_RST;
      redSourceLevel     <= epaper_cmd_pkg::RED_SRC_RST; // R10
      offTimingField     <= epaper_cmd_pkg::OFF_TIMING_RST;
      softStartA         <= epaper_cmd_pkg::SOFT_START_RST;
      softStartB         <= epaper_cmd_pkg::SOFT_START_RST;
      softStartC         <= epaper_cmd_pkg::SOFT_START_C_RST; // R15
      stateGateOnField   <= epaper_cmd_pkg::STATE_GATE_RST;
      extSourceField     <= epaper_cmd_pkg::EXT_SRC_RST;
      driveModeField     <= epaper_cmd_pkg::DRIVE_MODE_RST; // R22
    end else if (commit) begin // R23
      case (cmd_r)
        epaper_cmd_pkg::CMD_PANEL:
          if (pCnt_r > 3'h0) panelConfig <= pbuf_r[0]; // R9
        epaper_cmd_pkg::CMD_SUPPLY: begin // R10
          if (pCnt_r > 3'h0) supplySourceSelect <= pbuf_r[0][1:0]; // R8
          if (pCnt_r > 3'h1) supplyLevelSelect  <= pbuf_r[1][2:0];
          if (pCnt_r > 3'h2) sourceHighLevel    <= pbuf_r[2][5:0];
          if (pCnt_r > 3'h3) sourceLowLevel     <= pbuf_r[3][5:0];
          if (pCnt_r > 3'h4) redSourceLevel     <= pbuf_r[4][5:0];
        end
        epaper_cmd_pkg::CMD_OFF_SEQ:
          if (pCnt_r > 3'h0) offTimingField <=
            pbuf_r[0][epaper_cmd_pkg::OFF_TIMING_LSB +: 2]; // R12
        epaper_cmd_pkg::CMD_SOFT_START: begin // R15
          if (pCnt_r > 3'h0) softStartA <= pbuf_r[0];
          if (pCnt_r > 3'h1) softStartB <= pbuf_r[1];
          if (pCnt_r > 3'h2) softStartC <= pbuf_r[2][5:0]; // R8
        end
        epaper_cmd_pkg::CMD_WAVE_OPT: begin // R22
          if (pCnt_r > 3'h0) stateGateOnField <= pbuf_r[0][5:0];
          if (pCnt_r > 3'h1) begin
            extSourceField <= pbuf_r[1][epaper_cmd_pkg::EXT_SRC_LSB +: 2];
            driveModeField <= pbuf_r[1][epaper_cmd_pkg::DRIVE_MODE_LSB +: 3];
          end
        end
        default: ;
      endcase
    end
  end

  // Execution of action commands and the busy flag
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      exec_r       <= epaper_cmd_pkg::EX_IDLE;
      busyCnt_r    <= 16'h0000;
      supplyOn     <= 1'b0;
      refreshStart <= 1'b0;
      busyN        <= 1'b0;
      deepSleep    <= 1'b0;
      outputsFloat <= 1'b1; // R4
    end else if (ce) begin
      refreshStart <= 1'b0;
      outputsFloat <= !supplyOn; // R4
      busyN        <= exec_r == epaper_cmd_pkg::EX_IDLE; // R6
      deepSleep    <= exec_r == epaper_cmd_pkg::EX_SLEEP;
      case (exec_r)
        epaper_cmd_pkg::EX_IDLE:
          if (softReset) begin
            supplyOn <= 1'b0; // R4
          end else if (commit) begin
            case (cmd_r)
              epaper_cmd_pkg::CMD_PANEL:
                if (pCnt_r > 3'h0
                    && !pbuf_r[0][epaper_cmd_pkg::PANEL_BOOSTER_BIT])
                  supplyOn <= 1'b0; // R9
              epaper_cmd_pkg::CMD_POWER_OFF: begin // R11
                supplyOn  <= 1'b0;
                exec_r    <= epaper_cmd_pkg::EX_POWER;
                busyCnt_r <= 16'(BUSY_TICKS);
              end
              epaper_cmd_pkg::CMD_POWER_ON,
              epaper_cmd_pkg::CMD_POWER_ON_MEAS: begin // R13 R14
                supplyOn  <= 1'b1;
                exec_r    <= epaper_cmd_pkg::EX_POWER;
                busyCnt_r <= 16'(BUSY_TICKS);
              end
              epaper_cmd_pkg::CMD_REFRESH: begin // R19
                refreshStart <= 1'b1;
                exec_r       <= epaper_cmd_pkg::EX_REFRESH;
                busyCnt_r    <= 16'(BUSY_TICKS);
              end
              epaper_cmd_pkg::CMD_DEEP_SLEEP:
                if (pCnt_r > 3'h0
                    && pbuf_r[0] == epaper_cmd_pkg::CHECK_CODE) begin // R16
                  supplyOn <= 1'b0;
                  exec_r   <= epaper_cmd_pkg::EX_SLEEP;
                end
              epaper_cmd_pkg::CMD_AUTO:
                if (pCnt_r > 3'h0
                    && pbuf_r[0] == epaper_cmd_pkg::CHECK_CODE) begin // R21
                  supplyOn  <= 1'b1;
                  exec_r    <= epaper_cmd_pkg::EX_AUTO_ON;
                  busyCnt_r <= 16'(BUSY_TICKS);
                end
              default: ;
            endcase
          end
        epaper_cmd_pkg::EX_SLEEP: ;
        default:
          if (tick) begin
            if (busyCnt_r != 16'h0000) begin
              busyCnt_r <= busyCnt_r - 16'h0001;
            end else if (exec_r == epaper_cmd_pkg::EX_AUTO_ON) begin
              refreshStart <= 1'b1;
              exec_r       <= epaper_cmd_pkg::EX_AUTO_REFRESH;
              busyCnt_r    <= 16'(BUSY_TICKS);
            end else if (exec_r == epaper_cmd_pkg::EX_AUTO_REFRESH) begin
              supplyOn  <= 1'b0;
              exec_r    <= epaper_cmd_pkg::EX_AUTO_OFF;
              busyCnt_r <= 16'(BUSY_TICKS);
            end else begin
              exec_r <= epaper_cmd_pkg::EX_IDLE;
            end
          end
      endcase
    end
  end

  // Cascade timing tick: own divider as master, pin as slave
  assign tick = roleMaster_r
                ? (divCnt_r == 8'(TICK_DIV / 2 - 1) && !cascadeTickOut)
                : (tkS2 & ~tkS3); // R7

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      roleMaster_r   <= roleS2; // R7
      divCnt_r       <= 8'h00;
      cascadeTickOut <= 1'b0;
      cascadeTickOe  <= 1'b0;
    end else if (ce) begin
      cascadeTickOe <= roleMaster_r; // R7
      if (roleMaster_r) begin
        if (divCnt_r == 8'(TICK_DIV / 2 - 1)) begin
          divCnt_r       <= 8'h00;
          cascadeTickOut <= ~cascadeTickOut;
        end else begin
          divCnt_r <= divCnt_r + 8'h01;
        end
      end else begin
        cascadeTickOut <= 1'b0;
      end
    end
  end

  // Pixel planes
  always_ff @(posedge clk_sys) begin
    if (wrMono) monoMem[memAddr_r] <= link.byteData; // R17
    if (wrRed)  redMem[memAddr_r]  <= link.byteData; // R20
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      memRdMono <= 8'h00;
      memRdRed  <= 8'h00;
    end else if (ce && 32'(memRdAddr) < MEM_BYTES) begin
      memRdMono <= monoMem[memRdAddr];
      memRdRed  <= redMem[memRdAddr];
    end
  end

endmodule // epaper_cmd_front_end

//--- epaper_cmd_pkg.sv
// Shared constants, types and helpers of the e-paper command front end
package epaper_cmd_pkg;

  // Command codes
  localparam logic [7:0] CMD_PANEL         = 8'h00;
  localparam logic [7:0] CMD_SUPPLY        = 8'h01;
  localparam logic [7:0] CMD_POWER_OFF     = 8'h02;
  localparam logic [7:0] CMD_OFF_SEQ       = 8'h03;
  localparam logic [7:0] CMD_POWER_ON      = 8'h04;
  localparam logic [7:0] CMD_POWER_ON_MEAS = 8'h05;
  localparam logic [7:0] CMD_SOFT_START    = 8'h06;
  localparam logic [7:0] CMD_DEEP_SLEEP    = 8'h07;
  localparam logic [7:0] CMD_MONO_LOAD     = 8'h10;
  localparam logic [7:0] CMD_DATA_STOP     = 8'h11;
  localparam logic [7:0] CMD_REFRESH       = 8'h12;
  localparam logic [7:0] CMD_RED_LOAD      = 8'h13;
  localparam logic [7:0] CMD_AUTO          = 8'h17;
  localparam logic [7:0] CMD_WAVE_OPT      = 8'h2a;
  localparam logic [7:0] CMD_NONE          = 8'hff;
  localparam logic [7:0] CHECK_CODE        = 8'ha5;

  // Reset values
  localparam logic [7:0] PANEL_RST        = 8'h0f;
  localparam logic [1:0] SUPPLY_SRC_RST   = 2'h3;
  localparam logic [2:0] SUPPLY_LVL_RST   = 3'h0;
  localparam logic [5:0] SRC_HIGH_RST     = 6'h26;
  localparam logic [5:0] SRC_LOW_RST      = 6'h26;
  localparam logic [5:0] RED_SRC_RST      = 6'h03;
  localparam logic [1:0] OFF_TIMING_RST   = 2'h0;
  localparam logic [7:0] SOFT_START_RST   = 8'h17;
  localparam logic [5:0] SOFT_START_C_RST = 6'h17;
  localparam logic [5:0] STATE_GATE_RST   = 6'h00;
  localparam logic [1:0] EXT_SRC_RST      = 2'h0;
  localparam logic [2:0] DRIVE_MODE_RST   = 3'h0;

  // Field positions
  localparam int PANEL_SOFT_RST_BIT = 0;
  localparam int PANEL_BOOSTER_BIT  = 1;
  localparam int OFF_TIMING_LSB     = 4;
  localparam int EXT_SRC_LSB        = 4;
  localparam int DRIVE_MODE_LSB     = 0;
  localparam int STATUS_FLAG_BIT    = 7;

  // Serial frame lengths in bits
  localparam logic [3:0] FRAME_BITS_4W = 4'h8;
  localparam logic [3:0] FRAME_BITS_3W = 4'h9;

  // Pixel memory: one bit per pixel, eight pixels a byte
  localparam int FRAME_SRC  = 160;
  localparam int FRAME_GATE = 296;
  localparam int MEM_BYTES  = FRAME_SRC * FRAME_GATE / 8;
  localparam int MEM_AW     = 13;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_MIN_US  = 50;
  localparam int RESET_MIN_CYCLES =
    (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_TIME_NS  = 20000;
  localparam int BUSY_CYCLES   =
    (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_DIV      = 4;
  localparam int BUSY_TICKS    = BUSY_CYCLES / TICK_DIV;

  typedef enum logic [2:0] {
    EX_IDLE, EX_POWER, EX_REFRESH, EX_AUTO_ON, EX_AUTO_REFRESH,
    EX_AUTO_OFF, EX_SLEEP
  } exec_t;

  // Parameter bytes each command takes; zero for unknown codes
  function automatic logic [2:0] param_count(input logic [7:0] code);
    case (code)
      CMD_PANEL, CMD_OFF_SEQ, CMD_DEEP_SLEEP, CMD_AUTO: return 3'd1;
      CMD_SUPPLY:     return 3'd5;
      CMD_SOFT_START: return 3'd3;
      CMD_WAVE_OPT:   return 3'd2;
      default:        return 3'd0;
    endcase
  endfunction

  function automatic logic is_pixel_load(input logic [7:0] code);
    return (code == CMD_MONO_LOAD) || (code == CMD_RED_LOAD);
  endfunction

endpackage

//--- byte_link_if.sv
// Byte hand-over from the serial clock domain to the system domain
interface byte_link_if;
  logic [7:0] byteData;
  logic       byteIsData;
  logic       byteToggle;
  logic       firstBitSeen;
  logic       linkReset;

  modport rx   (output byteData, byteIsData, byteToggle, firstBitSeen,
                input linkReset);
  modport core (input byteData, byteIsData, byteToggle, firstBitSeen,
                output linkReset);
endinterface

//--- serial_byte_rx.sv
// Serial shifter on the host clock: 8-bit (4-wire) or 9-bit (3-wire) frames
module serial_byte_rx (
  // Host serial pins
  input  wire logic  sclk,
  input  wire logic  chipSelectPinN,
  input  wire logic  sdaIn,
  input  wire logic  cmdDataSelect,
  input  wire logic  busWidthSelect,
  // Byte hand-over
  byte_link_if.rx    link
);

  logic       bwsS1;
  logic       bwsS2;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic       isDataBit_r;
  logic       lastBit;

  always_ff @(posedge sclk) begin
    bwsS1 <= busWidthSelect;
    bwsS2 <= bwsS1;
  end

  // Frame length follows the bus width strap
  assign lastBit = bitCnt_r == ((bwsS2 ? epaper_cmd_pkg::FRAME_BITS_3W
                                      : epaper_cmd_pkg::FRAME_BITS_4W)
                                - 4'h1); // R1

  // Bit position restarts with every chip-select frame
  always_ff @(posedge sclk or posedge chipSelectPinN) begin
    if (chipSelectPinN) begin
      bitCnt_r          <= 4'h0;
      isDataBit_r       <= 1'b0;
      link.firstBitSeen <= 1'b0;
    end else begin
      bitCnt_r <= lastBit ? 4'h0 : bitCnt_r + 4'h1;
      shift_r  <= {shift_r[6:0], sdaIn};
      if (bwsS2 && bitCnt_r == 4'h0) begin
        isDataBit_r       <= sdaIn; // R2
        link.firstBitSeen <= 1'b1;
      end
    end
  end

  // Completed byte is held until the next one and flagged by a toggle
  always_ff @(posedge sclk or posedge link.linkReset) begin
    if (link.linkReset) begin
      link.byteData   <= 8'h00;
      link.byteIsData <= 1'b0;
      link.byteToggle <= 1'b0;
    end else if (!chipSelectPinN && lastBit) begin
      link.byteData   <= {shift_r[6:0], sdaIn};
      link.byteIsData <= bwsS2 ? isDataBit_r : cmdDataSelect; // R2
      link.byteToggle <= ~link.byteToggle;
    end
  end

endmodule // serial_byte_rx

//--- epaper_cmd_front_end_checker.sv
// Port assertions of the e-paper command front end
module epaper_cmd_front_end_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Observed ports
  input wire logic       busyN,
  input wire logic       supplyOn,
  input wire logic       outputsFloat,
  input wire logic       deepSleep,
  input wire logic       refreshStart,
  input wire logic       chipSelectPinN,
  input wire logic       sdaOe,
  input wire logic       cascadeRolePin,
  input wire logic       cascadeTickOut,
  input wire logic       cascadeTickOe,
  input wire logic [7:0] panelConfig,
  input wire logic [7:0] softStartA
);
  chk_reset_state: assert property (@(posedge clk_sys)
    !nrst |=> !busyN && !supplyOn && outputsFloat && !deepSleep)
    else $error("outputs not cleared by reset");
  chk_reset_regs: assert property (@(posedge clk_sys)
    !nrst |=> panelConfig == 8'h0f && softStartA == 8'h17)
    else $error("registers not at defaults in reset");
  chk_float_follow: assert property (@(posedge clk_sys)
    disable iff (!nrst) supplyOn |=> !outputsFloat)
    else $error("outputs float while supplies on");
  chk_refresh_pulse: assert property (@(posedge clk_sys)
    disable iff (!nrst) refreshStart |=> !refreshStart)
    else $error("refresh pulse longer than one cycle");
  chk_sleep_busy: assert property (@(posedge clk_sys)
    disable iff (!nrst) deepSleep ##1 deepSleep |-> !busyN ##1 deepSleep)
    else $error("deep sleep left or ready shown");
  chk_tick_role: assert property (@(posedge clk_sys)
    disable iff (!nrst) $past(nrst) |-> cascadeTickOe == cascadeRolePin)
    else $error("tick drive does not follow role");
  chk_tick_period: assert property (@(posedge clk_sys)
    disable iff (!nrst) $rose(cascadeTickOut) |=>
    cascadeTickOut ##1 !cascadeTickOut [*2] ##1 cascadeTickOut)
    else $error("tick period wrong");
  chk_read_start: assert property (@(posedge clk_sys)
    disable iff (!nrst) $rose(sdaOe) |-> !chipSelectPinN)
    else $error("data driven outside a frame");
  chk_read_end: assert property (@(posedge clk_sys)
    disable iff (!nrst) $rose(chipSelectPinN) |-> ##[1:8] !sdaOe)
    else $error("data line not released");
endmodule // epaper_cmd_front_end_checker

bind epaper_cmd_front_end epaper_cmd_front_end_checker i_chk (.*);

//--- host_spi_model.sv
// Host controller model driving the serial command link
module host_spi_model (
  // Serial pins toward the device
  output logic      sclk,
  output logic      chipSelectPinN,
  output logic      sdaIn,
  output logic      cmdDataSelect,
  // Device read-back
  input  wire logic sdaOut,
  input  wire logic sdaOe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    chipSelectPinN = 1'b1;
    sdaIn = 1'b0;
    cmdDataSelect = 1'b0;
  end
  task automatic beginFrame();
    chipSelectPinN = 1'b0;
    #30;
  endtask
  // One byte MSB first; three-wire adds a leading data/command bit
  task automatic put(input logic [7:0] b, input logic isData, input logic w3);
    logic [8:0] f;
    f = {isData, b};
    cmdDataSelect = w3 ? 1'b0 : isData;
    for (int i = (w3 ? 8 : 7); i >= 0; i--) begin
      sdaIn = f[i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
  endtask
  // Released line shows the inverse of the last bit
  task automatic endFrame();
    #15 chipSelectPinN = 1'b1;
    sdaIn = ~sdaIn;
  endtask
  task automatic getByte(output logic [7:0] b);
    chipSelectPinN = 1'b0;
    cmdDataSelect = 1'b1;
    sdaIn = ~sdaIn;
    #150;
    for (int i = 7; i >= 0; i--) begin
      #15 sclk = 1'b1;
      b[i] = sdaOe ? sdaOut : sdaIn;
      #15 sclk = 1'b0;
    end
    endFrame();
  endtask
endmodule // host_spi_model

//--- tb_top.sv
// Self-checking bench of the e-paper command front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1, seen = 1'b0;
  logic        busWidthSelect = 1'b0, cascadeRolePin = 1'b1;
  logic        cascadeTickIn = 1'b0;
  logic [12:0] memRdAddr = 13'h0;
  logic        sclk, chipSelectPinN, sdaIn, sdaOut, sdaOe, cmdDataSelect;
  logic        busyN, cascadeTickOut, cascadeTickOe, supplyOn, outputsFloat;
  logic        deepSleep, refreshStart;
  logic [7:0]  panelConfig, softStartA, softStartB, memRdMono, memRdRed, rd;
  logic [5:0]  sourceHighLevel, sourceLowLevel, redSourceLevel, softStartC;
  logic [5:0]  stateGateOnField;
  logic [2:0]  supplyLevelSelect, driveModeField;
  logic [1:0]  supplySourceSelect, offTimingField, extSourceField;
  int          num_errors = 0, num_checks = 0;
  epaper_cmd_front_end #(.BUSY_TICKS(4)) i_dut (.*);
  host_spi_model i_host (.*);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (refreshStart) seen <= 1'b1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits out commit and busy; the host sends only while ready
  task automatic settle();
    repeat (8) @(posedge clk_sys);
    for (int k = 0; k < 400 && !(busyN | deepSleep); k++)
      @(posedge clk_sys);
    chk(busyN | deepSleep, 1'b1);
    repeat (2) @(posedge clk_sys);
  endtask
  // Command byte then n parameters, first parameter in the low byte
  task automatic send(input logic [7:0] c, input int n, input logic [39:0] p);
    i_host.beginFrame();
    i_host.put(c, 1'b0, busWidthSelect);
    for (int i = 0; i < n; i++) i_host.put(p[8*i +: 8], 1'b1, busWidthSelect);
    i_host.endFrame();
    settle();
  endtask
  task automatic hard_reset(input int n);
    nrst <= 1'b0;
    repeat (n) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({panelConfig, softStartA, softStartB, 2'h0, softStartC},
      32'h0f171717);
    chk({supplySourceSelect, supplyLevelSelect, sourceHighLevel,
      sourceLowLevel, redSourceLevel}, 23'h626983);
    chk({offTimingField, stateGateOnField, extSourceField, driveModeField},
      13'h0);
    chk({busyN, deepSleep, supplyOn, outputsFloat}, 4'h9);
  endtask
  task automatic stop_test();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    hard_reset(12);
    send(8'h03, 2, 40'h10ff);
    chk(offTimingField, 2'h3);
    send(8'h3f, 1, 40'h00);
    send(8'h2a, 2, 40'hffff);
    chk({stateGateOnField, extSourceField, driveModeField}, 11'h7ff);
    chk(offTimingField, 2'h3);
    send(8'h00, 1, 40'h1f);
    chk(panelConfig, 8'h1f);
    send(8'h06, 3, 40'hff3c5a);
    chk({softStartA, softStartB, softStartC}, 22'h168f3f);
    send(8'h01, 5, 40'h1312110502);
    chk({supplySourceSelect, supplyLevelSelect, sourceHighLevel,
      sourceLowLevel, redSourceLevel}, 23'h551493);
    send(8'h04, 0, 40'h0);
    chk(supplyOn, 1'b1);
    send(8'h02, 0, 40'h0);
    chk({supplyOn, outputsFloat}, 2'h1);
    send(8'h05, 0, 40'h0);
    chk(supplyOn, 1'b1);
    seen = 1'b0;
    send(8'h17, 1, 40'h00);
    chk(seen, 1'b0);
    send(8'h17, 1, 40'ha5);
    chk(seen, 1'b1);
    seen = 1'b0;
    send(8'h12, 0, 40'h0);
    chk(seen, 1'b1);
    send(8'h10, 2, 40'h3ca5);
    send(8'h13, 1, 40'h81);
    send(8'h11, 0, 40'h0);
    i_host.getByte(rd);
    chk(rd[7], 1'b1);
    memRdAddr <= 13'h1;
    repeat (2) @(posedge clk_sys);
    chk(memRdMono, 8'h3c);
    memRdAddr <= 13'h0;
    repeat (2) @(posedge clk_sys);
    chk({memRdMono, memRdRed}, 16'ha581);
    busWidthSelect <= 1'b1;
    @(posedge clk_sys);
    send(8'h03, 1, 40'h20);
    chk(offTimingField, 2'h2);
    send(8'h07, 1, 40'h00);
    chk(deepSleep, 1'b0);
    send(8'h07, 1, 40'ha5);
    chk({deepSleep, busyN}, 2'h2);
    hard_reset(epaper_cmd_pkg::RESET_MIN_CYCLES);
    stop_test();
  end
  initial begin
    #500us;
    num_errors++;
    stop_test();
  end
endmodule // tb_top
